// [pkg/lpm_pkg.sv]
// package for the low-power pin multiplexer: types, reset values, pin layout
// assumes one 50 MHz always-on clock and a synchronous active-high reset
//
// Functional notes
// - in deep sleep the main pin mux is ignored; the low-power mux alone routes
// - low-power pin select and signal path stay alive through deep sleep
// - function zero makes pin n low-power gpio n for the low-power cpu
// - function one: pins 0-3 serial modem lines, pins 4-5 serial receive/transmit
// - function one: pin 6 two-wire data, pin 7 two-wire clock
// - function select is held per low-power gpio index, not package pin
// - converter channels 0-6 on pins 0-6 selectable in every power mode
// - pins 0 and 1 carry the slow crystal positive and negative terminals
// - after reset pins 12/13 belong to usb; software must release them
// - debug access may come from usb, freeing gpio 4 to 7
// - fixed directly wired pins win over the routing matrix
// - peripherals without fixed pins go through the matrix to any pin
// - usb data reaches only its fixed pins, never the matrix
// - unselected inputs read their constant: one for type one, zero otherwise
package lpm_pkg;

  // ---------------------------------------------------------------------------
  // sizes and enumerations
  // ---------------------------------------------------------------------------
  localparam int LPM_PINS = 8;
  localparam int LPM_ADC_CH = 7;

  typedef enum logic {
    LPM_FN_GPIO = 1'b0,
    LPM_FN_PERIPH = 1'b1
  } lpm_func_t;

  // ---------------------------------------------------------------------------
  // pin layout of the peripheral function
  // ---------------------------------------------------------------------------
  localparam int LPM_PIN_TERM_READY = 0;
  localparam int LPM_PIN_SET_READY = 1;
  localparam int LPM_PIN_REQ_SEND = 2;
  localparam int LPM_PIN_CLR_SEND = 3;
  localparam int LPM_PIN_RECEIVE = 4;
  localparam int LPM_PIN_TRANSMIT = 5;
  localparam int LPM_PIN_TW_DATA = 6;
  localparam int LPM_PIN_TW_CLOCK = 7;
  localparam int LPM_PIN_XTAL_P = 0;
  localparam int LPM_PIN_XTAL_N = 1;

  // peripheral inputs typed one (active-low modem inputs, receive, two-wire)
  localparam logic [7:0] LPM_PER_IN_DFLT = 8'hda;
  // gpio inputs are typed zero
  localparam logic [7:0] LPM_GPIO_IN_DFLT = 8'h00;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LPM_FSEL_RST = 8'h00;
  localparam logic LPM_USB_ATTACH_RST = 1'b1;
  localparam logic [7:0] LPM_PIN_IN_RST = 8'hff;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } lpm_drive_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] pin_in;
    logic [7:0] fsel;
    logic usb_attach;
    logic jtag_free;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] gpio_in;
    logic [7:0] per_in;
    logic [6:0] adc_en;
    logic xtal_en;
  } lpm_state_t;

endpackage : lpm_pkg

// [design/lpm_pin_slice.sv]
// one low-power pin: function mux, owner select and unselected-input constants
// assumes the filtered pad level and all drive requests are on the same clock
module lpm_pin_slice (
  input wire logic fsel_i,
  input wire logic lp_own_i,
  input wire logic analog_i,
  input wire logic pin_in_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic per_out_i,
  input wire logic per_oe_i,
  input wire logic per_dflt_i,
  input wire logic main_out_i,
  input wire logic main_oe_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic gpio_in_o,
  output logic per_in_o
);

  // ---------------------------------------------------------------------------
  // function and owner selection
  // ---------------------------------------------------------------------------
  always_comb begin
    logic lp_out;
    logic lp_oe;
    lp_out = gpio_out_i;
    lp_oe = gpio_oe_i;
    if (fsel_i == lpm_pkg::LPM_FN_PERIPH) begin
      lp_out = per_out_i;
      lp_oe = per_oe_i;
    end
    // low-power path when it owns the pin, else the main mux
    pad_out_o = lp_own_i ? lp_out : main_out_i;
    // an analog function keeps the digital driver off
    pad_oe_o = analog_i ? 1'b0 : (lp_own_i ? lp_oe : main_oe_i);
    // unselected inputs read their typed constant
    gpio_in_o = (fsel_i == lpm_pkg::LPM_FN_GPIO) ? pin_in_i : 1'b0;
    per_in_o = (fsel_i == lpm_pkg::LPM_FN_PERIPH) ? pin_in_i : per_dflt_i;
  end

endmodule : lpm_pin_slice

// [design/lpm_top.sv]
// low-power pin multiplexer for eight always-on pins, analog routing and
// the fixed usb/debug pin ownership
// assumes deep_sleep_i and all controls come from logic on ref_clk_i;
// pad inputs come from outside and are filtered here
module lpm_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic deep_sleep_i,
  input wire logic [7:0] lp_claim_i,
  input wire logic sel_wr_i,
  input wire logic [2:0] sel_idx_i,
  input wire lpm_pkg::lpm_func_t sel_func_i,
  output logic [7:0] sel_o,
  input wire logic [7:0] pad_in_i,
  output logic [7:0] pad_out_o,
  output logic [7:0] pad_oe_o,
  input wire lpm_pkg::lpm_drive_t gpio_drive_i,
  output logic [7:0] gpio_in_o,
  input wire logic low_power_serial_terminal_ready_n_i,
  output logic low_power_serial_set_ready_n_o,
  input wire logic low_power_serial_request_to_send_n_i,
  output logic low_power_serial_clear_to_send_n_o,
  output logic low_power_serial_receive_o,
  input wire logic low_power_serial_transmit_i,
  input wire logic low_power_two_wire_data_low_i,
  output logic low_power_two_wire_data_o,
  input wire logic low_power_two_wire_clock_low_i,
  output logic low_power_two_wire_clock_o,
  input wire lpm_pkg::lpm_drive_t main_fixed_i,
  input wire logic [7:0] main_fixed_en_i,
  input wire lpm_pkg::lpm_drive_t main_matrix_i,
  input wire logic [6:0] adc_sel_i,
  input wire logic xtal_sel_i,
  output logic [6:0] converter_channel_en_o,
  output logic slow_crystal_en_o,
  input wire logic usb_release_i,
  output logic usb_attach_o,
  input wire logic jtag_from_usb_i,
  output logic jtag_pins_free_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  lpm_pkg::lpm_state_t st_ff;
  lpm_pkg::lpm_state_t nxt_st;
  logic [7:0] lp_own;
  logic [7:0] analog;
  logic [7:0] per_out;
  logic [7:0] per_oe;
  logic [7:0] main_out;
  logic [7:0] main_oe;
  logic [7:0] sl_out;
  logic [7:0] sl_oe;
  logic [7:0] sl_gpio_in;
  logic [7:0] sl_per_in;

  // ---------------------------------------------------------------------------
  // peripheral and main-side drive requests
  // ---------------------------------------------------------------------------
  // serial outputs push-pull, inputs never driven; two-wire lines drive low only
  assign per_out = {1'b0, 1'b0, low_power_serial_transmit_i, 1'b0, 1'b0,
                    low_power_serial_request_to_send_n_i, 1'b0,
                    low_power_serial_terminal_ready_n_i};
  assign per_oe = {low_power_two_wire_clock_low_i, low_power_two_wire_data_low_i,
                   1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  // a fixed wired peripheral wins over the matrix; the matrix reaches any pin
  assign main_out = (main_fixed_en_i & main_fixed_i.out) |
                    (~main_fixed_en_i & main_matrix_i.out);
  assign main_oe = (main_fixed_en_i & main_fixed_i.oe) |
                   (~main_fixed_en_i & main_matrix_i.oe);
  // in deep sleep the main mux is dead, so the low-power path owns every pin
  assign lp_own = {8{deep_sleep_i}} | lp_claim_i;
  // analog selections stand in every power mode
  // pin 7 has no analog function; the slow crystal takes pins 0 and 1 only
  assign analog = {1'b0, st_ff.adc_en} |
                  {6'h00, {2{st_ff.xtal_en}}};

  // ---------------------------------------------------------------------------
  // per-pin slices
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < lpm_pkg::LPM_PINS; i++) begin : g_pin
    lpm_pin_slice u_slice (
      .fsel_i(st_ff.fsel[i]),
      .lp_own_i(lp_own[i]),
      .analog_i(analog[i]),
      .pin_in_i(st_ff.pin_in[i]),
      .gpio_out_i(gpio_drive_i.out[i]),
      .gpio_oe_i(gpio_drive_i.oe[i]),
      .per_out_i(per_out[i]),
      .per_oe_i(per_oe[i]),
      .per_dflt_i(lpm_pkg::LPM_PER_IN_DFLT[i]),
      .main_out_i(main_out[i]),
      .main_oe_i(main_oe[i]),
      .pad_out_o(sl_out[i]),
      .pad_oe_o(sl_oe[i]),
      .gpio_in_o(sl_gpio_in[i]),
      .per_in_o(sl_per_in[i])
    );
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // pad filter: three stages, a change counts once stage two and three agree
    nxt_st.s1 = pad_in_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < lpm_pkg::LPM_PINS; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.pin_in[i] = st_ff.s3[i];
      end
    end
    // select write addressed by low-power gpio index
    if (sel_wr_i) begin
      nxt_st.fsel[sel_idx_i] = sel_func_i;
    end
    // usb owns its data pins until software releases them
    if (usb_release_i) begin
      nxt_st.usb_attach = 1'b0;
    end
    nxt_st.jtag_free = jtag_from_usb_i;
    nxt_st.adc_en = adc_sel_i;
    nxt_st.xtal_en = xtal_sel_i;
    nxt_st.pad_out = sl_out;
    nxt_st.pad_oe = sl_oe;
    nxt_st.gpio_in = sl_gpio_in;
    nxt_st.per_in = sl_per_in;
    if (rst_i) begin
      nxt_st.s1 = lpm_pkg::LPM_PIN_IN_RST;
      nxt_st.s2 = lpm_pkg::LPM_PIN_IN_RST;
      nxt_st.s3 = lpm_pkg::LPM_PIN_IN_RST;
      nxt_st.pin_in = lpm_pkg::LPM_PIN_IN_RST;
      nxt_st.fsel = lpm_pkg::LPM_FSEL_RST;
      nxt_st.usb_attach = lpm_pkg::LPM_USB_ATTACH_RST;
      nxt_st.jtag_free = 1'b0;
      nxt_st.pad_out = 8'h00;
      nxt_st.pad_oe = 8'h00;
      nxt_st.gpio_in = lpm_pkg::LPM_GPIO_IN_DFLT;
      nxt_st.per_in = lpm_pkg::LPM_PER_IN_DFLT;
      nxt_st.adc_en = 7'h00;
      nxt_st.xtal_en = 1'b0;
    end
  end

  // register the whole state
  always_ff @(posedge ref_clk_i) begin
    st_ff <= nxt_st;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign sel_o = st_ff.fsel;
  assign pad_out_o = st_ff.pad_out;
  assign pad_oe_o = st_ff.pad_oe;
  assign gpio_in_o = st_ff.gpio_in;
  assign low_power_serial_set_ready_n_o = st_ff.per_in[lpm_pkg::LPM_PIN_SET_READY];
  assign low_power_serial_clear_to_send_n_o = st_ff.per_in[lpm_pkg::LPM_PIN_CLR_SEND];
  assign low_power_serial_receive_o = st_ff.per_in[lpm_pkg::LPM_PIN_RECEIVE];
  assign low_power_two_wire_data_o = st_ff.per_in[lpm_pkg::LPM_PIN_TW_DATA];
  assign low_power_two_wire_clock_o = st_ff.per_in[lpm_pkg::LPM_PIN_TW_CLOCK];
  assign converter_channel_en_o = st_ff.adc_en;
  assign slow_crystal_en_o = st_ff.xtal_en;
  assign usb_attach_o = st_ff.usb_attach;
  assign jtag_pins_free_o = st_ff.jtag_free;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_SLEEP_TRANSMIT: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (deep_sleep_i && st_ff.fsel[5] && !analog[5])
    |=> (pad_oe_o[5] && pad_out_o[5] == $past(low_power_serial_transmit_i)))
    else $error("transmit not routed to pin 5 in deep sleep");

  AST_GPIO_INPUT: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (!st_ff.fsel[2]) |=> (gpio_in_o[2] == $past(st_ff.pin_in[2])))
    else $error("low-power gpio 2 does not see its pin");

  AST_UNSEL_CONST: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (st_ff.fsel[0] && !st_ff.fsel[3])
    |=> (gpio_in_o[0] == 1'b0 && low_power_serial_clear_to_send_n_o == 1'b1))
    else $error("unselected input not at its constant");

  AST_SEL_RESET: assert property (
    @(posedge ref_clk_i)
    rst_i |=> (sel_o == 8'h00))
    else $error("function select not zero after reset");

  AST_SEL_WRITE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    sel_wr_i |=> (sel_o[$past(sel_idx_i)] == $past(sel_func_i)))
    else $error("select write lost");

  AST_ANALOG_ANY_MODE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    adc_sel_i[3] ##1 adc_sel_i[3] |=> (converter_channel_en_o[3] && !pad_oe_o[3]))
    else $error("converter channel 3 not routed or pin still driven");

  AST_USB_OWNERSHIP: assert property (
    @(posedge ref_clk_i)
    (rst_i |=> usb_attach_o) and (usb_release_i && !rst_i |=> !usb_attach_o))
    else $error("usb pin ownership wrong");

  AST_FIXED_WINS: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (!lp_own[3] && !analog[3] && main_fixed_en_i[3])
    |=> (pad_out_o[3] == $past(main_fixed_i.out[3]) &&
         pad_oe_o[3] == $past(main_fixed_i.oe[3])))
    else $error("fixed wiring did not win on pin 3");

  AST_TWO_WIRE_LOW: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (lp_own[6] && st_ff.fsel[6] && !analog[6])
    |=> (pad_out_o[6] == 1'b0 && pad_oe_o[6] == $past(low_power_two_wire_data_low_i)))
    else $error("two-wire data not open-drain on pin 6");

  AST_JTAG_FREE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    jtag_from_usb_i |=> jtag_pins_free_o)
    else $error("debug pins not freed");

endmodule : lpm_top

// [bench/lpm_far_model.sv]
// far-side model: low-power cpu gpio, low-power serial and two-wire masters
// assumes the bench sets wanted levels; they reach the mux at the falling edge
module lpm_far_model (
  input wire logic ref_clk_i,
  input wire lpm_pkg::lpm_drive_t want_drive_i,
  input wire logic [4:0] want_line_i,
  input wire logic want_release_i,
  output lpm_pkg::lpm_drive_t gpio_drive_o,
  output logic [4:0] line_o,
  output logic release_o
);
  timeunit 1ns;
  timeprecision 1ps;
  lpm_pkg::lpm_drive_t held_drive;
  logic [4:0] held_line;
  logic held_release;
  // quiet levels at time zero: gpio released, modem lines idle high
  initial begin
    gpio_drive_o = 16'h0000;
    line_o = 5'h1c;
    release_o = 1'b0;
    held_drive = 16'h0000;
    held_line = 5'h1c;
    held_release = 1'b0;
  end
  // wanted levels are taken at the rising edge, clear of the bench's falling-edge updates
  always @(posedge ref_clk_i) begin
    held_drive <= want_drive_i;
    held_line <= want_line_i;
    held_release <= want_release_i;
  end
  // drive changes only after the falling edge and holds for a whole cycle
  always @(negedge ref_clk_i) begin
    gpio_drive_o <= held_drive;
    line_o <= held_line;
    release_o <= held_release; // software hands pins 12/13 back
  end
endmodule : lpm_far_model

// [bench/lpm_top_tb.sv]
// self-checking bench for the low-power pin multiplexer
// assumes one 50 MHz clock; inputs change at the falling edge
module lpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic deep_sleep_i = 1'b0;
  logic [7:0] lp_claim_i = 8'h00;
  logic sel_wr_i = 1'b0;
  logic [2:0] sel_idx_i = 3'h0;
  lpm_pkg::lpm_func_t sel_func_i = lpm_pkg::LPM_FN_GPIO;
  logic [7:0] pad_in_i = 8'hff;
  lpm_pkg::lpm_drive_t want_drive = 16'h0000;
  lpm_pkg::lpm_drive_t main_fixed_i = 16'h0000;
  lpm_pkg::lpm_drive_t main_matrix_i = 16'h0000;
  lpm_pkg::lpm_drive_t gpio_drive;
  logic [7:0] main_fixed_en_i = 8'h00;
  logic [6:0] adc_sel_i = 7'h00;
  logic xtal_sel_i = 1'b0;
  logic jtag_from_usb_i = 1'b0;
  logic [4:0] want_line = 5'h1c;
  logic want_release = 1'b0;
  logic [4:0] line;
  logic rel;
  logic [7:0] sel_o, pad_out_o, pad_oe_o, gpio_in_o;
  logic set_n, cts_n, rx, sda, scl, xtal_en, usb_attach, jtag_free;
  logic [6:0] conv_en;
  wire logic [7:0] per_in = {3'h0, set_n, cts_n, rx, sda, scl};
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  // ---------------------------------------------------------------------------
  // clock, partner and design
  // ---------------------------------------------------------------------------
  always #10 ref_clk_i = ~ref_clk_i;
  lpm_far_model far (.ref_clk_i(ref_clk_i), .want_drive_i(want_drive),
    .want_line_i(want_line), .want_release_i(want_release),
    .gpio_drive_o(gpio_drive), .line_o(line), .release_o(rel));
  lpm_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .deep_sleep_i(deep_sleep_i),
    .lp_claim_i(lp_claim_i), .sel_wr_i(sel_wr_i), .sel_idx_i(sel_idx_i),
    .sel_func_i(sel_func_i), .sel_o(sel_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .gpio_drive_i(gpio_drive),
    .gpio_in_o(gpio_in_o), .low_power_serial_terminal_ready_n_i(line[4]),
    .low_power_serial_set_ready_n_o(set_n),
    .low_power_serial_request_to_send_n_i(line[3]),
    .low_power_serial_clear_to_send_n_o(cts_n), .low_power_serial_receive_o(rx),
    .low_power_serial_transmit_i(line[2]), .low_power_two_wire_data_low_i(line[1]),
    .low_power_two_wire_data_o(sda), .low_power_two_wire_clock_low_i(line[0]),
    .low_power_two_wire_clock_o(scl), .main_fixed_i(main_fixed_i),
    .main_fixed_en_i(main_fixed_en_i), .main_matrix_i(main_matrix_i),
    .adc_sel_i(adc_sel_i), .xtal_sel_i(xtal_sel_i), .converter_channel_en_o(conv_en),
    .slow_crystal_en_o(xtal_en), .usb_release_i(rel), .usb_attach_o(usb_attach),
    .jtag_from_usb_i(jtag_from_usb_i), .jtag_pins_free_o(jtag_free));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  // back-to-back select writes to every low-power gpio index
  task automatic set_all(input logic f);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      sel_wr_i = 1'b1;
      sel_idx_i = 3'(i);
      sel_func_i = lpm_pkg::lpm_func_t'(f);
    end
    @(negedge ref_clk_i);
    sel_wr_i = 1'b0;
  endtask : set_all
  task automatic give_verdict;
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // hang guard: the sequence needs well under 200 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 600) begin
      failures++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(5);
    rst_i = 1'b0;
    tick(1);
    chk("sel", 8'h00, sel_o);
    chk("pad_oe", 8'h00, pad_oe_o);
    chk("gpio_in", 8'hff, gpio_in_o);
    chk("per_in", 8'h1f, per_in);
    chk("usb", 8'h01, {7'h00, usb_attach});
    // deep sleep, peripheral function, main mux pushing everywhere
    deep_sleep_i = 1'b1;
    main_fixed_i = 16'hffff;
    main_fixed_en_i = 8'hff;
    want_drive = 16'hffff;
    want_line = 5'h0a;
    set_all(1'b1);
    tick(3);
    chk("sel", 8'hff, sel_o);
    chk("pad_oe", 8'h65, pad_oe_o);
    chk("pad_out", 8'h04, pad_out_o & 8'h65);
    pad_in_i = 8'h00;
    tick(6);
    chk("per_in", 8'h00, per_in);
    chk("gpio_in", 8'h00, gpio_in_o);
    // back to gpio function under the low-power cpu
    set_all(1'b0);
    want_drive = 16'ha5ff;
    pad_in_i = 8'h3c;
    tick(6);
    chk("pad_out", 8'ha5, pad_out_o);
    chk("pad_oe", 8'hff, pad_oe_o);
    chk("gpio_in", 8'h3c, gpio_in_o);
    chk("per_in", 8'h1f, per_in);
    // awake: fixed wiring beats the routing matrix
    deep_sleep_i = 1'b0;
    main_fixed_i = 16'h33ff;
    main_fixed_en_i = 8'h0f;
    main_matrix_i = 16'hccff;
    tick(3);
    chk("pad_out", 8'hc3, pad_out_o);
    // awake: claimed pins follow the low-power gpio, the rest stay on the main mux
    lp_claim_i = 8'hf0;
    tick(3);
    chk("pad_out", 8'ha3, pad_out_o);
    // analog routing in deep sleep
    deep_sleep_i = 1'b1;
    adc_sel_i = 7'h7f;
    tick(4);
    chk("conv", 8'h7f, {1'b0, conv_en});
    chk("pad_oe", 8'h80, pad_oe_o);
    adc_sel_i = 7'h00;
    xtal_sel_i = 1'b1;
    tick(4);
    chk("xtal", 8'h01, {7'h00, xtal_en});
    chk("pad_oe", 8'hfc, pad_oe_o);
    // usb release, debug source, then a second reset
    want_release = 1'b1;
    tick(1);
    want_release = 1'b0;
    jtag_from_usb_i = 1'b1;
    tick(3);
    chk("usb", 8'h00, {7'h00, usb_attach});
    chk("jtag", 8'h01, {7'h00, jtag_free});
    set_all(1'b1);
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(1);
    chk("sel", 8'h00, sel_o);
    chk("usb", 8'h01, {7'h00, usb_attach});
    give_verdict();
  end
endmodule : lpm_top_tb
